// ==== design/cfm_edge_watch.sv ====
/*
 edge watcher: synchronises one monitored clock pin, reports its
 rising edges and flags a dead clock after a quiet interval.
 assumes the monitored clock is well below half the core clock.
*/
`timescale 1ns/1ns
module cfm_edge_watch
   import cfm_pkg::*;
(
   input  wire logic core_clk,
   input  wire logic resetn,
   input  wire logic pinClk,
   input  wire logic watchEn,
   output logic      edgeSeen,
   output logic      clkDead
);
   logic       meta_r;
   logic       sync_r;
   logic       prev_r;
   logic [7:0] quiet_r;

   // ****************************************
   // two-stage synchroniser
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         prev_r <= 1'b0;
      end else begin
         meta_r <= pinClk;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   assign edgeSeen = sync_r & ~prev_r;

   // ****************************************
   // quiet-interval counter
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (!resetn || !watchEn || edgeSeen) begin
         quiet_r <= 8'h00;
      end else if (quiet_r != 8'(FAIL_CYC)) begin
         quiet_r <= quiet_r + 8'h01;
      end
   end

   assign clkDead = watchEn && (quiet_r == 8'(FAIL_CYC));
endmodule : cfm_edge_watch

// ==== design/cfm_pkg.sv ====
/*
 package of the clock failure monitor: register map, field
 positions, reset values, source and mode codes, timing counts.
 assumes a single 20 MHz core clock from the internal RC clock.
*/
// Functional notes
// - watch the clock in use; on failure switch automatically to the internal clock.
// - power-managed mode routes the source named in clock_select_control to the core.
// - supervision of the clock in use continues inside power-managed modes.
// - failure with interrupt enabled: keep executing on the internal clock.
// - never return to a failed source without explicit software reselection.
// - interrupt disabled, failure seen: interrupt in idle resumes core on internal clock.
// - external, RC or internal primary: supervision active right after reset or wake; the code never watches a MODE_IRC primary.
// - crystal modes run on internal clock until start-up and lock timers expire.
// - stable crystal clock takes over the core; internal clock returns to sampling.
// - a never-starting oscillator raises no failure flag; software times start status.
// - selecting another mode while waiting for the primary disables the primary.
package cfm_pkg;
   // ****************************************
   // register map
   // ****************************************
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STAT = 4'h4;
   localparam int CTRL_SEL_LO = 0;
   localparam int CTRL_INTEN  = 2;
   localparam int CTRL_IDLE   = 3;
   localparam int CTRL_SLEEP  = 4;
   localparam int STAT_FAIL   = 0;
   localparam int STAT_STRT   = 1;
   localparam int STAT_SRC_LO = 2;
   localparam int STAT_SAFE   = 4;
   localparam int STAT_RUN    = 5;
   localparam logic [1:0] RESP_OK  = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;
   // ****************************************
   // clock sources and primary modes
   // ****************************************
   localparam logic [1:0] SRC_PRI = 2'h0;
   localparam logic [1:0] SRC_SEC = 2'h1;
   localparam logic [1:0] SRC_INT = 2'h2;
   localparam logic [1:0] SEL_RST = 2'h0;
   localparam logic [2:0] MODE_LOWX  = 3'h0;
   localparam logic [2:0] MODE_STDX  = 3'h1;
   localparam logic [2:0] MODE_FASTX = 3'h2;
   localparam logic [2:0] MODE_MULX  = 3'h3;
   localparam logic [2:0] MODE_EXTC  = 3'h4;
   localparam logic [2:0] MODE_RCN   = 3'h5;
   localparam logic [2:0] MODE_IRC   = 3'h6;
   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_NS  = 50;
   localparam int CLK_MHZ = 20;
   localparam int FAIL_NS = 3200;
   localparam int FAIL_CYC = FAIL_NS / CLK_NS;
   localparam logic [10:0] START_EDGES = 11'h400;
   localparam int PLL_LOCK_US = 2000;
   localparam int PLL_LOCK_CYC_DEF = PLL_LOCK_US * CLK_MHZ;
   // ****************************************
   // sequencer states
   // ****************************************
   typedef enum logic [4:0] {
      ST_START = 5'h01,
      ST_PRI   = 5'h02,
      ST_ALT   = 5'h04,
      ST_FAIL  = 5'h08,
      ST_SLEEP = 5'h10
   } cfm_state_e;
endpackage : cfm_pkg

// ==== design/cfm_top.sv ====
/*
 clock failure monitor with start-up sequencer and AXI4-Lite
 register slave; drives clock select and enable controls.
 assumes clock pins arrive asynchronous, mode straps are static.
*/
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
module cfm_top
   import cfm_pkg::*;
#(
   parameter int unsigned PLL_LOCK_CYC = cfm_pkg::PLL_LOCK_CYC_DEF
) (
   input  wire logic       core_clk,
   input  wire logic       resetn,
   input  wire logic [3:0] s_axi_awaddr,
   input  wire logic       s_axi_awvalid,
   output logic            s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0] s_axi_wstrb,
   input  wire logic       s_axi_wvalid,
   output logic            s_axi_wready,
   output logic [1:0]      s_axi_bresp,
   output logic            s_axi_bvalid,
   input  wire logic       s_axi_bready,
   input  wire logic [3:0] s_axi_araddr,
   input  wire logic       s_axi_arvalid,
   output logic            s_axi_arready,
   output logic [31:0]     s_axi_rdata,
   output logic [1:0]      s_axi_rresp,
   output logic            s_axi_rvalid,
   input  wire logic       s_axi_rready,
   input  wire logic [2:0] cfgOscMode,
   input  wire logic       priClkPin,
   input  wire logic       secClkPin,
   input  wire logic       irqIn,
   input  wire logic       wakeIn,
   output logic [1:0]      clkSel,
   output logic            priOscEn,
   output logic            cpuRun,
   output logic            oscFailIntFlag
);
   import cfm_pkg::*;

   // ****************************************
   // decoding helpers
   // ****************************************
   function automatic logic isCrystal(input logic [2:0] m);
      isCrystal = (m == MODE_LOWX) || (m == MODE_STDX) ||
                  (m == MODE_FASTX) || (m == MODE_MULX);
   endfunction : isCrystal

   function automatic logic [1:0] srcOf(input cfm_state_e s,
                                       input logic [1:0] sel);
      case (s)
         ST_PRI:  srcOf = SRC_PRI;
         ST_ALT:  srcOf = sel;
         default: srcOf = SRC_INT;
      endcase
   endfunction : srcOf

   function automatic logic mapped(input logic [3:0] a);
      mapped = (a == ADDR_CTRL) || (a == ADDR_STAT);
   endfunction : mapped

   // ****************************************
   // declarations
   // ****************************************
   cfm_state_e  state_r;
   cfm_state_e  state_nxt;
   logic [1:0]  selSrc_r;
   logic        failIntEn_r;
   logic        idle_r;
   logic        idle_nxt;
   logic        failFlag_r;
   logic [1:0]  clkSel_r;
   logic        priOscEn_r;
   logic        cpuRun_r;
   logic        awGot_r;
   logic        wGot_r;
   logic [3:0]  awAddr_r;
   logic [31:0] wData_r;
   logic [3:0]  wStrb_r;
   logic        bvalid_r;
   logic [1:0]  bresp_r;
   logic        rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0]  rresp_r;
   logic        doWrite;
   logic        ctrlWr;
   logic        statWr;
   logic [1:0]  newSel;
   logic        wakeSync1_r;
   logic        wakeSync_r;
   logic        irqSync1_r;
   logic        irqSync_r;
   logic [10:0] startEdges_r;
   logic [15:0] lockCnt_r;
   logic        startDone;
   logic        priEdge;
   logic        priDead;
   logic        secDead;
   logic        priWatch;
   logic        secWatch;
   logic        failDet;

   // ****************************************
   // AXI4-Lite write channel
   // ****************************************
   assign s_axi_awready = !awGot_r && !bvalid_r;
   assign s_axi_wready  = !wGot_r && !bvalid_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign doWrite = awGot_r && wGot_r && !bvalid_r;
   assign ctrlWr  = doWrite && (awAddr_r == ADDR_CTRL) && wStrb_r[0];
   assign statWr  = doWrite && (awAddr_r == ADDR_STAT) && wStrb_r[0];
   assign newSel  = (wData_r[CTRL_SEL_LO +: 2] == SRC_SEC) ? SRC_SEC :
                    (wData_r[CTRL_SEL_LO +: 2] == SRC_PRI) ? SRC_PRI : SRC_INT;

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         awGot_r  <= 1'b0;
         awAddr_r <= 4'h0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         awGot_r  <= 1'b1;
         awAddr_r <= s_axi_awaddr;
      end else if (doWrite) begin
         awGot_r  <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         wGot_r  <= 1'b0;
         wData_r <= 32'h0000_0000;
         wStrb_r <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         wGot_r  <= 1'b1;
         wData_r <= s_axi_wdata;
         wStrb_r <= s_axi_wstrb;
      end else if (doWrite) begin
         wGot_r  <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         bvalid_r <= 1'b0;
         bresp_r  <= RESP_OK;
      end else if (doWrite) begin
         bvalid_r <= 1'b1;
         bresp_r  <= mapped(awAddr_r) ? RESP_OK : RESP_ERR;
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // ****************************************
   // AXI4-Lite read channel
   // ****************************************
   assign s_axi_arready = !rvalid_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h0000_0000;
         rresp_r  <= RESP_OK;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_r <= 1'b1;
         rresp_r  <= mapped(s_axi_araddr) ? RESP_OK : RESP_ERR;
         rdata_r  <= 32'h0000_0000;
         if (s_axi_araddr == ADDR_CTRL) begin
            rdata_r[CTRL_SEL_LO +: 2] <= selSrc_r;
            rdata_r[CTRL_INTEN]       <= failIntEn_r;
            rdata_r[CTRL_IDLE]        <= idle_r;
         end else if (s_axi_araddr == ADDR_STAT) begin
            rdata_r[STAT_FAIL]        <= failFlag_r;
            rdata_r[STAT_STRT]        <= (state_r == ST_PRI);
            rdata_r[STAT_SRC_LO +: 2] <= clkSel_r;
            rdata_r[STAT_SAFE]        <= (state_r == ST_FAIL);
            rdata_r[STAT_RUN]         <= cpuRun_r;
         end
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // ****************************************
   // control register
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         selSrc_r    <= SEL_RST;
         failIntEn_r <= 1'b0;
      end else if (ctrlWr) begin
         selSrc_r    <= newSel;
         failIntEn_r <= wData_r[CTRL_INTEN];
      end
   end

   // ****************************************
   // pin synchronisers for wake and interrupt
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         wakeSync1_r <= 1'b0;
         wakeSync_r  <= 1'b0;
         irqSync1_r  <= 1'b0;
         irqSync_r   <= 1'b0;
      end else begin
         wakeSync1_r <= wakeIn;
         wakeSync_r  <= wakeSync1_r;
         irqSync1_r  <= irqIn;
         irqSync_r   <= irqSync1_r;
      end
   end

   // ****************************************
   // clock watchers
   // ****************************************
   assign priWatch = (state_r == ST_PRI) && (cfgOscMode != MODE_IRC);
   assign secWatch = (state_r == ST_ALT) && (selSrc_r == SRC_SEC);
   assign failDet  = (priWatch && priDead) || (secWatch && secDead);

   cfm_edge_watch u_priWatch (
      .core_clk (core_clk),
      .resetn   (resetn),
      .pinClk   (priClkPin),
      .watchEn  (priWatch),
      .edgeSeen (priEdge),
      .clkDead  (priDead)
   );

   cfm_edge_watch u_secWatch (
      .core_clk (core_clk),
      .resetn   (resetn),
      .pinClk   (secClkPin),
      .watchEn  (secWatch),
      .edgeSeen (),
      .clkDead  (secDead)
   );

   // ****************************************
   // start-up and lock timers
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (!resetn || state_r != ST_START) begin
         startEdges_r <= 11'h000;
      end else if (priEdge && startEdges_r != START_EDGES) begin
         startEdges_r <= startEdges_r + 11'h001;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn || state_r != ST_START) begin
         lockCnt_r <= 16'h0000;
      end else if (lockCnt_r != 16'(PLL_LOCK_CYC)) begin
         lockCnt_r <= lockCnt_r + 16'h0001;
      end
   end

   assign startDone = !isCrystal(cfgOscMode) ||
                      ((startEdges_r == START_EDGES) &&
                       (cfgOscMode != MODE_MULX ||
                        lockCnt_r == 16'(PLL_LOCK_CYC)));

   // ****************************************
   // sequencer
   // ****************************************
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_START: begin
            if (ctrlWr && wData_r[CTRL_SLEEP]) begin
               state_nxt = ST_SLEEP;
            end else if (ctrlWr && newSel != SRC_PRI) begin
               state_nxt = ST_ALT;
            end else if (startDone) begin
               state_nxt = ST_PRI;
            end
         end
         ST_PRI, ST_ALT: begin
            if (failDet) begin
               state_nxt = ST_FAIL;
            end else if (ctrlWr && wData_r[CTRL_SLEEP]) begin
               state_nxt = ST_SLEEP;
            end else if (ctrlWr && newSel == SRC_PRI) begin
               state_nxt = (state_r == ST_PRI) ? ST_PRI : ST_START;
            end else if (ctrlWr) begin
               state_nxt = ST_ALT;
            end
         end
         ST_FAIL: begin
            if (ctrlWr && wData_r[CTRL_SLEEP]) begin
               state_nxt = ST_SLEEP;
            end else if (ctrlWr) begin
               state_nxt = (newSel == SRC_PRI) ? ST_START : ST_ALT;
            end
         end
         ST_SLEEP: begin
            if (wakeSync_r) begin
               state_nxt = (selSrc_r == SRC_PRI) ? ST_START : ST_ALT;
            end
         end
         default: state_nxt = ST_START;
      endcase
   end

   always_comb begin
      idle_nxt = idle_r;
      if (state_nxt == ST_SLEEP) begin
         idle_nxt = 1'b0;
      end else if (failDet && failIntEn_r) begin
         idle_nxt = 1'b0;
      end else if (irqSync_r) begin
         idle_nxt = 1'b0;
      end else if (ctrlWr && wData_r[CTRL_IDLE]) begin
         idle_nxt = 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         state_r    <= ST_START;
         idle_r     <= 1'b0;
         clkSel_r   <= SRC_INT;
         priOscEn_r <= 1'b1;
         cpuRun_r   <= 1'b1;
      end else begin
         state_r    <= state_nxt;
         idle_r     <= idle_nxt;
         clkSel_r   <= srcOf(state_nxt, ctrlWr ? newSel : selSrc_r);
         priOscEn_r <= (state_nxt == ST_START) || (state_nxt == ST_PRI);
         cpuRun_r   <= !idle_nxt && (state_nxt != ST_SLEEP);
      end
   end

   // ****************************************
   // failure flag, set wins over clear
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         failFlag_r <= 1'b0;
      end else if (failDet) begin
         failFlag_r <= 1'b1;
      end else if (statWr && wData_r[STAT_FAIL]) begin
         failFlag_r <= 1'b0;
      end
   end

   assign clkSel         = clkSel_r;
   assign priOscEn       = priOscEn_r;
   assign cpuRun         = cpuRun_r;
   assign oscFailIntFlag = failFlag_r;

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   chk_fail_to_int: assert property (
      failDet |=> clkSel_r == SRC_INT && failFlag_r && state_r == ST_FAIL)
      else $error("failure did not move to internal clock");

   chk_alt_route: assert property (
      state_r == ST_ALT |-> clkSel_r == selSrc_r)
      else $error("mode source not routed");

   chk_sec_watch: assert property (
      secWatch && secDead |=> state_r == ST_FAIL && failFlag_r)
      else $error("secondary clock unsupervised");

   chk_int_resume: assert property (
      failDet && failIntEn_r |=> cpuRun_r && clkSel_r == SRC_INT)
      else $error("core not running after enabled failure");

   chk_no_return: assert property (
      state_r == ST_FAIL && !ctrlWr |=> state_r == ST_FAIL)
      else $error("left failed state without reselection");

   chk_idle_wake: assert property (
      state_r == ST_FAIL && idle_r && irqSync_r && !ctrlWr
      |=> !idle_r && cpuRun_r && clkSel_r == SRC_INT)
      else $error("interrupt did not resume core");

   chk_ext_watch: assert property (
      state_r == ST_PRI && !isCrystal(cfgOscMode)
      && cfgOscMode != MODE_IRC |-> priWatch)
      else $error("external primary unsupervised");

   chk_start_int: assert property (
      state_r == ST_START |-> clkSel_r == SRC_INT && !priWatch)
      else $error("start-up not on internal clock");

   chk_handover: assert property (
      state_r == ST_START && state_nxt == ST_PRI
      |=> clkSel_r == SRC_PRI ##1 priWatch || state_r != ST_PRI)
      else $error("stable primary not handed over");

   chk_no_start_flag: assert property (
      state_r == ST_START && !failFlag_r |=> !failFlag_r)
      else $error("flag raised during start-up");

   chk_abort_start: assert property (
      state_r == ST_START && ctrlWr && newSel != SRC_PRI |=> !priOscEn_r)
      else $error("primary kept on after mode change");
endmodule : cfm_top

// ==== test/cfm_osc_model.sv ====
/*
 behavioural clock source on the far side of the monitor: a
 crystal or external clock that toggles while enabled and alive.
 assumes the bench controls alive to model a dead or late source.
*/
`timescale 1ns/1ns
module cfm_osc_model #(
   parameter int HALF_NS = 200
) (
   input  wire logic oscEn,
   input  wire logic alive,
   output logic      pin
);
   // ****************************************
   // clock generation
   // ****************************************
   initial begin
      pin = 1'b0;
      forever begin
         #(HALF_NS);
         // a stopped or disabled source stands still
         if (oscEn && alive) begin
            pin = ~pin;
         end
      end
   end
endmodule : cfm_osc_model

// ==== test/fail_safe_clock_monitor_test.sv ====
/*
 self-checking bench of the clock monitor: AXI4-Lite tasks and
 scenarios for failure, fallback, start-up and power-managed modes.
 assumes the design package and the oscillator model are compiled.
*/
`timescale 1ns/1ns
module fail_safe_clock_monitor_test;
   import cfm_pkg::*;
   logic core_clk, resetn, irqIn, wakeIn, priAlive, secAlive;
   logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [1:0] s_axi_bresp, s_axi_rresp, clkSel, rsp;
   logic [2:0] cfgOscMode;
   logic priClkPin, secClkPin, priOscEn, cpuRun, oscFailIntFlag;
   int errors, checks, cyc, n;

   cfm_top #(.PLL_LOCK_CYC(8)) u_cfm_top (
      .core_clk(core_clk), .resetn(resetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .cfgOscMode(cfgOscMode), .priClkPin(priClkPin), .secClkPin(secClkPin),
      .irqIn(irqIn), .wakeIn(wakeIn), .clkSel(clkSel), .priOscEn(priOscEn),
      .cpuRun(cpuRun), .oscFailIntFlag(oscFailIntFlag)
   );
   cfm_osc_model #(.HALF_NS(200)) u_pri (.oscEn(priOscEn), .alive(priAlive),
                                         .pin(priClkPin));
   cfm_osc_model #(.HALF_NS(300)) u_sec (.oscEn(1'b1), .alive(secAlive),
                                         .pin(secClkPin));

   // ****************************************
   // clock, timeout and shared tasks
   // ****************************************
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   task automatic results;
      $display("comparisons %0d mismatches %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : results

   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         errors = errors + 1;
         results();
      end
   end

   task automatic compare(input logic [31:0] seen, input logic [31:0] exp);
      checks = checks + 1;
      if (seen !== exp) begin
         errors = errors + 1;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : compare

   task automatic doReset(input logic [2:0] mode);
      cfgOscMode <= mode;
      resetn     <= 1'b0;
      repeat (12) @(posedge core_clk);
      resetn <= 1'b1;
      @(posedge core_clk);
   endtask : doReset

   task automatic axiWrite(input logic [3:0] a, input logic [31:0] d,
                           output logic [1:0] r);
      bit aw, w, b;
      aw = 0;
      w  = 0;
      b  = 0;
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      while (!b) begin
         @(posedge core_clk);
         if (!aw && s_axi_awready) begin
            aw = 1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w && s_axi_wready) begin
            w = 1;
            s_axi_wvalid <= 1'b0;
         end
         if (s_axi_bvalid) begin
            b = 1;
            r = s_axi_bresp;
         end
      end
   endtask : axiWrite

   task automatic axiRead(input logic [3:0] a, output logic [31:0] d,
                          output logic [1:0] r);
      bit ar, got;
      ar  = 0;
      got = 0;
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      while (!got) begin
         @(posedge core_clk);
         if (!ar && s_axi_arready) begin
            ar = 1;
            s_axi_arvalid <= 1'b0;
         end
         if (s_axi_rvalid) begin
            got = 1;
            d = s_axi_rdata;
            r = s_axi_rresp;
         end
      end
   endtask : axiRead

   task automatic waitSel(input logic [1:0] s, input int lim);
      for (n = 0; n < lim && clkSel !== s; n++) @(posedge core_clk);
   endtask : waitSel

   task automatic waitFlag(input int lim);
      for (n = 0; n < lim && oscFailIntFlag !== 1'b1; n++) @(posedge core_clk);
   endtask : waitFlag

   // ****************************************
   // scenarios
   // ****************************************
   initial begin
      errors = 0;
      checks = 0;
      cyc = 0;
      resetn = 1'b0;
      cfgOscMode = MODE_EXTC;
      irqIn = 1'b0;
      wakeIn = 1'b0;
      priAlive = 1'b1;
      secAlive = 1'b1;
      s_axi_awaddr = 4'h0;
      s_axi_araddr = 4'h0;
      s_axi_wstrb = 4'hF;
      s_axi_wdata = 32'h0;
      // response readies stay high for the whole run
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h05;
      // external clock supervised at once, failure falls back
      doReset(MODE_EXTC);
      waitSel(SRC_PRI, 4);
      compare(clkSel, SRC_PRI);
      repeat (100) @(posedge core_clk);
      compare(oscFailIntFlag, 1'b0);
      priAlive <= 1'b0;
      waitFlag(80);
      compare(oscFailIntFlag, 1'b1);
      compare(clkSel, SRC_INT);
      axiRead(ADDR_STAT, rd, rsp);
      compare(rd & 32'h0000000D, {28'h0, SRC_INT, 2'h1});
      priAlive <= 1'b1;
      repeat (100) @(posedge core_clk);
      compare(clkSel, SRC_INT);
      axiWrite(ADDR_STAT, 32'h1, rsp);
      axiRead(ADDR_STAT, rd, rsp);
      compare(rd[STAT_FAIL], 1'b0);
      axiRead(4'h8, rd, rsp);
      compare(rd, 32'h0);
      compare(rsp, RESP_ERR);
      axiWrite(4'hC, 32'h1, rsp);
      compare(rsp, RESP_ERR);
      axiWrite(ADDR_CTRL, 32'h0, rsp);
      waitSel(SRC_PRI, 20);
      compare(clkSel, SRC_PRI);
      // idle on secondary, failure with interrupt enabled
      axiWrite(ADDR_CTRL, 32'hD, rsp);
      compare(clkSel, SRC_SEC);
      compare(cpuRun, 1'b0);
      secAlive <= 1'b0;
      waitFlag(80);
      @(posedge core_clk);
      compare(oscFailIntFlag, 1'b1);
      compare(clkSel, SRC_INT);
      compare(cpuRun, 1'b1);
      // interrupt disabled: idle holds until an interrupt
      axiWrite(ADDR_STAT, 32'h1, rsp);
      secAlive <= 1'b1;
      axiWrite(ADDR_CTRL, 32'h9, rsp);
      waitSel(SRC_SEC, 10);
      compare(clkSel, SRC_SEC);
      secAlive <= 1'b0;
      waitFlag(80);
      repeat (20) @(posedge core_clk);
      compare(cpuRun, 1'b0);
      compare(clkSel, SRC_INT);
      irqIn <= 1'b1;
      for (n = 0; n < 10 && cpuRun !== 1'b1; n++) @(posedge core_clk);
      compare(cpuRun, 1'b1);
      compare(clkSel, SRC_INT);
      irqIn <= 1'b0;
      // crystal with multiplier: internal clock until stable
      priAlive <= 1'b0;
      secAlive <= 1'b1;
      doReset(MODE_MULX);
      repeat (300) @(posedge core_clk);
      compare(clkSel, SRC_INT);
      compare(oscFailIntFlag, 1'b0);
      axiRead(ADDR_STAT, rd, rsp);
      compare(rd[STAT_STRT], 1'b0);
      priAlive <= 1'b1;
      waitSel(SRC_PRI, 9000);
      compare(clkSel, SRC_PRI);
      compare(n >= 8000, 1'b1);
      axiRead(ADDR_STAT, rd, rsp);
      compare(rd[STAT_STRT], 1'b1);
      // new mode chosen while waiting for the crystal
      priAlive <= 1'b0;
      doReset(MODE_STDX);
      repeat (20) @(posedge core_clk);
      compare(priOscEn, 1'b1);
      axiWrite(ADDR_CTRL, {30'h0, SRC_SEC}, rsp);
      waitSel(SRC_SEC, 10);
      compare(clkSel, SRC_SEC);
      compare(priOscEn, 1'b0);
      // sleep from the secondary source, wake back onto it
      axiWrite(ADDR_CTRL, 32'h11, rsp);
      compare(cpuRun, 1'b0);
      compare(clkSel, SRC_INT);
      wakeIn <= 1'b1;
      waitSel(SRC_SEC, 10);
      compare(clkSel, SRC_SEC);
      compare(cpuRun, 1'b1);
      wakeIn <= 1'b0;
      results();
   end
endmodule : fail_safe_clock_monitor_test
